// ### rtl/bcdscn_cfg.svh
/*
 Constants for the six-decade counter and digit scanner: timing counts, digit count, blank code and FIFO depth.
 Assumes a 100 MHz system clock; included by the top-level design file only.
*/
`ifndef BCDSCN_CFG_SVH
`define BCDSCN_CFG_SVH
`define BCDSCN_CLK_HZ 100000000
`define BCDSCN_SCAN_HZ 1000
`define BCDSCN_SCAN_CYC (`BCDSCN_CLK_HZ / `BCDSCN_SCAN_HZ)
`define BCDSCN_HOLD_MS 1000
`define BCDSCN_HOLD_CYC (`BCDSCN_CLK_HZ / 1000 * `BCDSCN_HOLD_MS)
`define BCDSCN_DIGITS 6
`define BCDSCN_BLANK_CODE 4'hf
`define BCDSCN_FIFO_DEPTH 32
`endif

// ### rtl/bcdscn_pkg.sv
/*
 Types shared by the counter/scanner design.
 Assumes the cfg header is included where constants are needed.
*/
package bcdscn_pkg;
	typedef enum logic [1:0] {
		bcdscn_idle,
		bcdscn_hold,
		bcdscn_wait_turn,
		bcdscn_transfer
	} bcdscn_mode_t;

	typedef struct packed {
		logic [3:0] digit;
		logic [2:0] pos;
	} bcdscn_item_t;

	typedef struct packed {
		logic [3:0] data;
		logic [5:0] select;
		logic blank;
	} bcdscn_disp_t;
endpackage : bcdscn_pkg

// ### rtl/bcdscn_mem.sv
/*
 Small dual-port memory for the FIFO; read data come out of a register.
 Assumes one clock shared by both ports.
*/
`timescale 1ns/10ps
module bcdscn_mem #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			store[wr_addr] <= wr_data;
		end
		rd_data <= store[rd_addr];
	end
endmodule : bcdscn_mem

// ### rtl/bcdscn_fifo.sv
/*
 Show-ahead FIFO with valid/ready on both sides, built on bcdscn_mem.
 Assumes synchronous active-high reset on sys_clk.
*/
`timescale 1ns/10ps
module bcdscn_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
		logic out_valid;
	} bcdscn_fifo_st_t;

	bcdscn_fifo_st_t st_ff;
	bcdscn_fifo_st_t nxt_st;
	logic push;
	logic pop;
	logic load;
	logic [AW-1:0] rd_addr;

	// The memory read is registered, so the head word is fetched one cycle ahead into the output stage.
	assign in_ready = (st_ff.count != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = st_ff.out_valid && out_ready;
	assign load = (st_ff.count != '0) && (!st_ff.out_valid || pop);
	assign rd_addr = st_ff.rd_ptr;
	assign out_valid = st_ff.out_valid;

	bcdscn_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
		.sys_clk(sys_clk),
		.wr_en(push),
		.wr_addr(st_ff.wr_ptr),
		.wr_data(in_data),
		.rd_addr(rd_addr),
		.rd_data(out_data)
	);

	always_comb
	begin
		nxt_st = st_ff;
		if (push)
		begin
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
		end
		if (load)
		begin
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
		end
		nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(load);
		if (load)
		begin
			nxt_st.out_valid = 1'b1;
		end
		else if (pop)
		begin
			nxt_st.out_valid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end
endmodule : bcdscn_fifo

// ### rtl/bcdscn_top.sv
/*
 Six-decade gated BCD pulse counter with overflow, digit scanner and printer-loop transfer port.
 Assumes all inputs synchronous to sys_clk; count pulses are one-cycle strobes.
*/
`timescale 1ns/10ps
`include "bcdscn_cfg.svh"
module bcdscn_top
	import bcdscn_pkg::*;
#(
	parameter int DIGITS = `BCDSCN_DIGITS,
	parameter int SCAN_CYC = `BCDSCN_SCAN_CYC,
	parameter int HOLD_CYC = `BCDSCN_HOLD_CYC,
	parameter int FIFO_DEPTH = `BCDSCN_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic pos_pulse,
	input wire logic neg_pulse,
	input wire logic count_stop_switch,
	input wire logic ext_gate,
	input wire logic print_request,
	input wire logic print_advance,
	input wire logic previous_module_done,
	output logic own_module_done,
	output logic gate_indicator,
	output logic overflow_pulse,
	output logic overflow_flag,
	output logic [3:0] sys_data_out,
	output logic sys_data_oe,
	output logic sys_data_valid,
	output logic [3:0] disp_data,
	output logic [DIGITS-1:0] disp_select,
	output logic disp_blank,
	output logic msd_select,
	output logic lsd_select,
	output logic pulse_ready
);
	localparam int SCW = $clog2(SCAN_CYC);
	localparam int HCW = $clog2(HOLD_CYC + 1);
	localparam logic [2:0] LAST_POS = 3'(DIGITS - 1);

	typedef struct packed {
		logic [DIGITS-1:0][3:0] count;
		logic ovf_pulse;
		logic ovf_flag;
		logic [2:0] pos;
		logic [SCW-1:0] tick_cnt;
		logic [HCW-1:0] hold_cnt;
		bcdscn_mode_t mode;
		logic done;
		logic [3:0] sys_data;
		logic sys_oe;
		bcdscn_disp_t disp;
	} bcdscn_st_t;

	bcdscn_st_t st_ff;
	bcdscn_st_t nxt_st;
	logic gate_open;
	logic counting;
	logic scan_step;
	logic tick;
	logic [DIGITS:0] carry;
	logic [DIGITS-1:0][3:0] nxt_count;
	logic [3:0] cur_digit;
	bcdscn_item_t fifo_in;
	bcdscn_item_t fifo_out;
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_in_ready;

	assign gate_open = count_stop_switch && ext_gate;
	assign counting = gate_open && (st_ff.mode == bcdscn_idle);
	assign gate_indicator = counting;

	// Pulses are queued so that a burst arriving while the chain ripples is not lost; a full queue stalls the source.
	assign fifo_in.digit = 4'h1;
	assign fifo_in.pos = 3'h0;
	assign fifo_in_valid = counting && (pos_pulse || neg_pulse);
	assign pulse_ready = fifo_in_ready;

	bcdscn_fifo #(.WIDTH($bits(bcdscn_item_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1),
		.out_data(fifo_out)
	);

	// BCD ripple chain; each decade carries from nine to zero.
	assign carry[0] = fifo_out_valid && (fifo_out.digit != 4'h0);
	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++)
		begin : g_decade
			always_comb
			begin
				nxt_count[gi] = st_ff.count[gi];
				carry[gi+1] = 1'b0;
				if (carry[gi])
				begin
					if (st_ff.count[gi] == 4'h9)
					begin
						nxt_count[gi] = 4'h0;
						carry[gi+1] = 1'b1;
					end
					else
					begin
						nxt_count[gi] = st_ff.count[gi] + 4'h1;
					end
				end
			end
		end
	endgenerate

	assign tick = (st_ff.tick_cnt == SCW'(SCAN_CYC - 1));
	assign scan_step = (st_ff.mode == bcdscn_transfer) ? print_advance : (st_ff.mode == bcdscn_idle && tick);
	assign cur_digit = st_ff.count[LAST_POS - st_ff.pos];

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.count = nxt_count;
		nxt_st.ovf_pulse = carry[DIGITS];
		if (carry[DIGITS])
		begin
			nxt_st.ovf_flag = 1'b1;
		end
		nxt_st.tick_cnt = tick ? '0 : st_ff.tick_cnt + 1'b1;
		if (scan_step)
		begin
			nxt_st.pos = (st_ff.pos == LAST_POS) ? 3'h0 : st_ff.pos + 3'h1;
		end
		nxt_st.disp.data = cur_digit;
		nxt_st.disp.select = 6'(DIGITS'(1) << st_ff.pos);
		nxt_st.disp.blank = 1'b0;
		nxt_st.sys_data = cur_digit;
		unique case (st_ff.mode)
			bcdscn_idle:
			begin
				nxt_st.done = 1'b0;
				nxt_st.sys_oe = 1'b0;
				if (print_request)
				begin
					nxt_st.mode = bcdscn_hold;
					nxt_st.hold_cnt = '0;
					nxt_st.pos = 3'h0;
					nxt_st.disp.blank = 1'b1;
				end
			end
			bcdscn_hold:
			begin
				nxt_st.disp.blank = 1'b1;
				nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;
				if (st_ff.hold_cnt == HCW'(HOLD_CYC - 1))
				begin
					nxt_st.mode = bcdscn_wait_turn;
				end
			end
			bcdscn_wait_turn:
			begin
				nxt_st.disp.blank = 1'b1;
				nxt_st.pos = 3'h0;
				if (previous_module_done && !st_ff.done)
				begin
					nxt_st.mode = bcdscn_transfer;
					nxt_st.sys_oe = 1'b1;
					// The top digit must be lit from the first cycle that it stands on the shared lines.
					nxt_st.disp.blank = 1'b0;
				end
				if (!print_request)
				begin
					nxt_st.mode = bcdscn_idle;
					nxt_st.done = 1'b0;
				end
			end
			bcdscn_transfer:
			begin
				// Only the digit on the shared lines is lit.
				if (scan_step && st_ff.pos == LAST_POS)
				begin
					nxt_st.mode = bcdscn_wait_turn;
					nxt_st.sys_oe = 1'b0;
					nxt_st.done = 1'b1;
					nxt_st.disp.blank = 1'b1;
				end
				else
				begin
					nxt_st.disp.blank = 1'b0;
				end
			end
		endcase
		if (st_ff.mode == bcdscn_wait_turn && st_ff.done)
		begin
			nxt_st.mode = print_request ? bcdscn_wait_turn : bcdscn_idle;
		end
	end

	// Reset clears the register in one step, so no false carry reaches the overflow pulse.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			st_ff <= '0;
			st_ff.mode <= bcdscn_idle;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign own_module_done = st_ff.done;
	assign overflow_pulse = st_ff.ovf_pulse;
	assign overflow_flag = st_ff.ovf_flag;
	assign sys_data_out = st_ff.sys_oe ? st_ff.sys_data : 4'h0;
	assign sys_data_oe = st_ff.sys_oe;
	assign sys_data_valid = st_ff.sys_oe;
	assign disp_data = st_ff.disp.blank ? `BCDSCN_BLANK_CODE : st_ff.disp.data;
	assign disp_select = st_ff.disp.blank ? '0 : st_ff.disp.select[DIGITS-1:0];
	assign disp_blank = st_ff.disp.blank;
	assign msd_select = (st_ff.pos == 3'h0);
	assign lsd_select = (st_ff.pos == LAST_POS);
endmodule : bcdscn_top

// ### tb/bcdscn_props.sv
/*
 Port assertions for bcdscn_top, bound at the foot of this file.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module bcdscn_props #(
	parameter int DIGITS = 6
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic count_stop_switch,
	input wire logic ext_gate,
	input wire logic print_request,
	input wire logic previous_module_done,
	input wire logic own_module_done,
	input wire logic gate_indicator,
	input wire logic overflow_pulse,
	input wire logic overflow_flag,
	input wire logic [3:0] sys_data_out,
	input wire logic sys_data_oe,
	input wire logic sys_data_valid,
	input wire logic [DIGITS-1:0] disp_select,
	input wire logic disp_blank,
	input wire logic msd_select,
	input wire logic lsd_select
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	AST_OE_TURN: assert property (sys_data_oe |-> $past(print_request) && $past(previous_module_done))
		else $error("lines driven off turn");
	AST_OE_QUIET: assert property (!sys_data_oe |-> sys_data_out == 4'h0)
		else $error("data while released");
	AST_VALID: assert property (sys_data_valid == sys_data_oe)
		else $error("valid differs from drive");
	AST_BLANK_SEL: assert property (disp_blank |-> disp_select == '0)
		else $error("select while blank");
	AST_ENDS: assert property (!(msd_select && lsd_select))
		else $error("two selects");
	AST_WRAP: assert property ($fell(lsd_select) && !print_request |-> msd_select)
		else $error("no wrap to top digit");
	AST_PRINT_BLANK: assert property ($rose(print_request) |=> disp_blank)
		else $error("no blank on print");
	AST_DONE: assert property ($rose(own_module_done) |-> !sys_data_oe && ($past(sys_data_oe) || $past(sys_data_oe, 2)))
		else $error("done without release");
	AST_OVF_SET: assert property (overflow_pulse |=> overflow_flag)
		else $error("flag not set");
	AST_OVF_HOLD: assert property (overflow_flag |=> overflow_flag)
		else $error("flag lost");
	AST_GATE: assert property (gate_indicator |-> count_stop_switch && ext_gate)
		else $error("gate lit while inhibited");
endmodule : bcdscn_props
bind bcdscn_top bcdscn_props #(.DIGITS(DIGITS)) u_props (.*);

// ### tb/bcdscn_loop_model.sv
/*
 Printer-loop controller model: print level, turn grant, advance strobes.
 Assumes the block's outputs settle within 1 ns of the clock edge.
*/
`timescale 1ns/10ps
module bcdscn_loop_model #(
	parameter int HOLD = 20
) (
	input wire logic sys_clk,
	input wire logic start,
	input wire logic slow,
	input wire logic [3:0] sys_data_out,
	input wire logic sys_data_oe,
	input wire logic [5:0] disp_select,
	input wire logic [3:0] disp_data,
	input wire logic own_module_done,
	output logic print_request,
	output logic previous_module_done,
	output logic print_advance,
	output logic [23:0] digits,
	output logic fin,
	output int bad
);
	int k;
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step
	initial
	begin
		print_request = 1'b0;
		previous_module_done = 1'b0;
		print_advance = 1'b0;
		digits = 24'h0;
		fin = 1'b1;
		bad = 0;
		forever
		begin
			@(posedge sys_clk);
			if (start)
			begin
				#1;
				fin = 1'b0;
				bad = 0;
				print_request = 1'b1;
				repeat (HOLD + 4) step();
				previous_module_done = 1'b1;
				for (int i = 0; i < 6; i++)
				begin
					for (k = 0; !sys_data_oe && k < 50; k++) step();
					digits[23 - 4 * i -: 4] = sys_data_out;
					if (sys_data_oe !== 1'b1 || disp_select !== (6'h01 << i) || disp_data !== sys_data_out)
						bad++;
					// A stall longer than a scan tick shows the oscillator no longer moves the digit.
					if (slow)
						repeat (20) step();
					if (sys_data_out !== digits[23 - 4 * i -: 4])
						bad++;
					print_advance = 1'b1;
					step();
					print_advance = 1'b0;
					repeat (2) step();
				end
				for (k = 0; !own_module_done && k < 10; k++) step();
				if (own_module_done !== 1'b1 || sys_data_oe !== 1'b0)
					bad++;
				print_request = 1'b0;
				previous_module_done = 1'b0;
				fin = 1'b1;
			end
		end
	end
endmodule : bcdscn_loop_model

// ### tb/tb.sv
/*
 Self-checking bench for bcdscn_top with the printer-loop model.
 Scan and hold counts are scaled down; one 100 MHz clock.
*/
`timescale 1ns/10ps
module tb;
	localparam int SCAN = 8;
	localparam int HOLD = 20;
	logic sys_clk = 1'b0, reset = 1'b1, pos_pulse = 1'b0, neg_pulse = 1'b0;
	logic count_stop_switch = 1'b0, ext_gate = 1'b0, start = 1'b0, slow = 1'b0, frozen = 1'b0;
	logic print_request, print_advance, previous_module_done, own_module_done, gate_indicator, fin;
	logic overflow_pulse, overflow_flag, sys_data_oe, sys_data_valid, disp_blank, msd_select, lsd_select, pulse_ready;
	logic [3:0] sys_data_out, disp_data;
	logic [5:0] disp_select;
	logic [23:0] digits;
	logic ovf_pulse_s, ovf_flag_s;
	int n_ovf = 0;
	int bad, k, p, c;
	int seed = 61, exp_cnt = 0, error_cnt = 0, n_tests = 0;
	always #5 sys_clk = ~sys_clk;
	bcdscn_top #(.SCAN_CYC(SCAN), .HOLD_CYC(HOLD)) uut (.*);
	bcdscn_loop_model #(.HOLD(HOLD)) u_loop (.*);
	// A two-decade copy sees the same inputs, so its overflow comes after a hundred counts, not a million.
	bcdscn_top #(.DIGITS(2), .SCAN_CYC(SCAN), .HOLD_CYC(HOLD)) uut_ovf (
		.sys_clk(sys_clk),
		.reset(reset),
		.pos_pulse(pos_pulse),
		.neg_pulse(neg_pulse),
		.count_stop_switch(count_stop_switch),
		.ext_gate(ext_gate),
		.print_request(print_request),
		.print_advance(print_advance),
		.previous_module_done(previous_module_done),
		.own_module_done(),
		.gate_indicator(),
		.overflow_pulse(ovf_pulse_s),
		.overflow_flag(ovf_flag_s),
		.sys_data_out(),
		.sys_data_oe(),
		.sys_data_valid(),
		.disp_data(),
		.disp_select(),
		.disp_blank(),
		.msd_select(),
		.lsd_select(),
		.pulse_ready()
	);
	// The pulse stands from one rising edge to the next, so the falling edge sees it exactly once.
	always @(negedge sys_clk)
	begin
		if (ovf_pulse_s === 1'b1)
			n_ovf++;
	end
	function automatic logic [23:0] to_bcd(input int n);
		logic [23:0] r;
		for (int i = 0; i < 6; i++)
		begin
			r[4 * i +: 4] = 4'(n % 10);
			n = n / 10;
		end
		return r;
	endfunction : to_bcd
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step
	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// A pulse is expected to count only if the gate is open and the FIFO can take it.
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			p = $random(seed);
			pos_pulse = p[0];
			neg_pulse = !p[0] && p[1];
			if ((pos_pulse || neg_pulse) && count_stop_switch && ext_gate && pulse_ready && !frozen)
				exp_cnt++;
			step();
		end
		pos_pulse = 1'b0;
		neg_pulse = 1'b0;
	endtask : pulses
	task automatic do_print(input logic s);
		repeat (8) step();
		slow = s;
		start = 1'b1;
		step();
		start = 1'b0;
		repeat (6) step();
		frozen = 1'b1;
		pulses(30);
		frozen = 1'b0;
		for (k = 0; !fin && k < 600; k++) step();
		if (!fin)
		begin
			error_cnt++;
			$display("MISMATCH %0t loop hang", $time);
			results();
		end
		check(digits === to_bcd(exp_cnt), "digits");
		check(bad == 0, "transfer");
		// The block leaves print one edge after the request drops; pulses before that are refused.
		repeat (2) step();
	endtask : do_print
	initial
	begin
		repeat (16) step();
		reset = 1'b0;
		check(sys_data_oe === 1'b0 && own_module_done === 1'b0 && overflow_flag === 1'b0, "reset");
		for (c = 0; msd_select && c < 100; c++) step();
		for (c = 0; !msd_select && c < 100; c++) step();
		for (c = 0; msd_select && c < 100; c++) step();
		for (k = c; !msd_select && k < 200; k++) step();
		check(k == 6 * SCAN, "scan period");
		for (int g = 0; g < 4; g++)
		begin
			count_stop_switch = g[0];
			ext_gate = g[1];
			step();
			check(gate_indicator === (g == 3), "gate");
			pulses(40);
		end
		pulses(150);
		do_print(1'b0);
		pulses(120);
		do_print(1'b1);
		check(ovf_flag_s === (exp_cnt >= 100) && n_ovf == exp_cnt / 100, "overflow");
		reset = 1'b1;
		repeat (16) step();
		reset = 1'b0;
		check(n_ovf == exp_cnt / 100 && ovf_flag_s === 1'b0 && overflow_flag === 1'b0, "reset clear");
		exp_cnt = 0;
		do_print(1'b0);
		results();
	end
endmodule : tb
